/* File: bench/ssi_interlock_checker.sv */
// Port assertions for the spindle safety interlock.
module ssi_interlock_checker
  import ssi_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register writes
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  // Commands and machine inputs
  input wire logic        contour_to_position_cmd,
  input wire logic        contour_to_speed_cmd,
  input wire logic        tool_release_cmd,
  input wire logic        spindle_start_req,
  input wire logic        cycle_start_req,
  input wire logic        auto_mode,
  input wire logic        alarm_reset,
  input wire logic        gate_feedback_in,
  // Outputs
  input wire logic        spindle_mode_switch_out,
  input wire logic        spindle_run_out,
  input wire logic        coolant_out,
  input wire logic        tool_release_out,
  input wire logic        auto_running,
  input wire logic        gate_open_notice,
  input wire logic        alarm_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Shadow configuration, since the checker cannot see the registers.
  logic [7:0] cfg_reg;
  logic [1:0] ctl_reg;
  wire cs_en  = ctl_reg[SSI_CTRL_CS_EN];
  wire tc_en  = ctl_reg[SSI_CTRL_CLAMP_EN];
  wire g_open = cfg_reg[SSI_GATE_EN_BIT] && (gate_feedback_in != cfg_reg[SSI_GATE_POL_BIT]);
  wire al_clr = alarm_reset || (reg_write && reg_addr == SSI_ADDR_ALARM);
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg <= 8'h00;
      ctl_reg <= 2'h0;
    end else if (reg_write && reg_addr == SSI_ADDR_GATE_CFG)
      cfg_reg <= reg_wdata[7:0];
    else if (reg_write && reg_addr == SSI_ADDR_CTRL)
      ctl_reg <= reg_wdata[1:0];
  end
  // ==========================================================================
  // Assertions
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  a_pos_sets_switch: assert property (cs_en && contour_to_position_cmd
    && !contour_to_speed_cmd && !alarm_active |=> spindle_mode_switch_out) else $error("no switch");
  a_spd_clears_switch: assert property (cs_en && contour_to_speed_cmd
    && !contour_to_position_cmd && !alarm_active |=> !spindle_mode_switch_out) else $error("switch");
  a_contour_stops_spin: assert property (cs_en && !alarm_active && !spindle_start_req
    && (contour_to_position_cmd || contour_to_speed_cmd) |=> !spindle_run_out) else $error("spin");
  a_alarm_latched: assert property (alarm_active && !al_clr |=> alarm_active)
    else $error("alarm dropped");
  a_start_released: assert property (tc_en && tool_release_out && !spindle_run_out
    && spindle_start_req |=> !spindle_run_out ##[0:1] alarm_active) else $error("start taken");
  a_tool_rotating: assert property (tc_en && spindle_run_out && tool_release_cmd
    && !tool_release_out |=> !tool_release_out ##[0:1] alarm_active) else $error("tool moved");
  a_gate_start: assert property (g_open && $stable(gate_feedback_in) && auto_mode
    && cycle_start_req && !auto_running |=> !auto_running ##[0:1] alarm_active) else $error("ran");
  a_gate_halt: assert property (g_open && auto_running
    |-> ##[1:2] !auto_running) else $error("no halt");
  a_gate_shut: assert property (g_open && auto_running
    && !cfg_reg[SSI_GATE_KEEP_BIT] |-> ##[1:2] (!spindle_run_out && !coolant_out))
    else $error("outputs kept");
  a_gate_notice: assert property (g_open [*2] |=> gate_open_notice)
    else $error("no notice");
  a_release_drive: assert property (tc_en && tool_release_cmd && !spindle_run_out
    && !alarm_active |=> tool_release_out) else $error("no release");
  c_halt: cover property (auto_running ##1 !auto_running);
  c_release: cover property ($rose(tool_release_out));
  c_mode: cover property ($rose(spindle_mode_switch_out));
endmodule // ssi_interlock_checker

bind ssi_interlock ssi_interlock_checker u_chk (.*);

/* File: bench/ssi_interlock_tb.sv */
// Self-checking testbench for the spindle safety interlock.
module ssi_interlock_tb
  import ssi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 0, S = 1, REL = 2, CLP = 3, SON = 4, SOF = 5, CON = 6, COF = 7;
  localparam int CYC = 8, CST = 9, ARS = 10;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [10:0] cmd = 11'h000;
  logic        auto_mode = 1'b0;
  logic        mpg_mode = 1'b0;
  logic        gate_feedback_in = 1'b0;
  logic        manual_release_key = 1'b0;
  logic        mode_stall = 1'b0;
  logic        tool_stall = 1'b0;
  logic [15:0] reg_rdata;
  logic spindle_mode_feedback, release_in_position, clamp_in_position, spindle_mode_switch_out;
  logic spindle_run_out, coolant_out, tool_release_out, auto_running, gate_open_notice;
  logic alarm_active;
  int fails = 0;
  int checked = 0;
  ssi_interlock #(.TICK_CYCLES(2)) uut (.*, .contour_to_position_cmd(cmd[P]),
    .contour_to_speed_cmd(cmd[S]), .tool_release_cmd(cmd[REL]), .tool_clamp_cmd(cmd[CLP]),
    .spindle_start_req(cmd[SON]), .spindle_stop_req(cmd[SOF]), .coolant_on_req(cmd[CON]),
    .coolant_off_req(cmd[COF]), .cycle_start_req(cmd[CYC]), .cycle_stop_req(cmd[CST]),
    .alarm_reset(cmd[ARS]));
  ssi_partner #(.LAT(3)) u_partner (.*);
  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ck(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    cmd[i] <= 1'b1;
    @(posedge clk);
    cmd[i] <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_alarm();
    int n = 0;
    while (alarm_active !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    if (n == 60) begin
      fails++;
      $display("ERROR at %0t alarm %h expected %h", $time, alarm_active, 1'b1);
      stop_test();
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd(SSI_ADDR_GATE_CFG, {8'h00, SSI_GATE_CFG_RST});
    rd(SSI_ADDR_CS_DELAY, SSI_CS_DELAY_RST);
    rd(SSI_ADDR_CLAMP_DLY, SSI_CLAMP_DLY_RST);
    rd(SSI_ADDR_STATUS, 16'h0001);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    wr(SSI_ADDR_CS_DELAY, 16'h0006);
    wr(SSI_ADDR_CLAMP_DLY, 16'h0006);
    rd(SSI_ADDR_CLAMP_DLY, 16'h0006);
  endtask
  task automatic t_contour();
    wr(SSI_ADDR_CTRL, 16'h0001);
    pulse(SON);
    pulse(P);
    ck(spindle_mode_switch_out, 1'b1);
    ck(spindle_run_out, 1'b0);
    idle(20);
    ck(alarm_active, 1'b0);
    pulse(S);
    ck(spindle_mode_switch_out, 1'b0);
    idle(6);
    mode_stall <= 1'b1;
    pulse(P);
    idle(3);
    ck(alarm_active, 1'b0);
    wait_alarm();
    rd(SSI_ADDR_ALARM, 16'h0001);
    idle(5);
    ck(alarm_active, 1'b1);
    pulse(ARS);
    mode_stall <= 1'b0;
    rd(SSI_ADDR_ALARM, 16'h0000);
    pulse(S);
    pulse(SOF);
  endtask
  task automatic t_gate();
    wr(SSI_ADDR_GATE_CFG, 16'h0003);
    gate_feedback_in <= 1'b1;
    auto_mode <= 1'b1;
    pulse(SON);
    pulse(CON);
    pulse(CYC);
    ck(auto_running, 1'b1);
    gate_feedback_in <= 1'b0;
    idle(3);
    ck(auto_running, 1'b0);
    ck(gate_open_notice, 1'b1);
    chk({spindle_run_out, coolant_out}, 16'h0000);
    gate_feedback_in <= 1'b1;
    idle(2);
    pulse(CYC);
    idle(1);
    chk({auto_running, spindle_run_out, coolant_out}, 16'h0007);
    wr(SSI_ADDR_GATE_CFG, 16'h0007);
    gate_feedback_in <= 1'b0;
    idle(3);
    chk({auto_running, spindle_run_out, coolant_out}, 16'h0003);
    pulse(CYC);
    idle(1);
    ck(auto_running, 1'b0);
    rd(SSI_ADDR_ALARM, 16'h0002);
    pulse(ARS);
    wr(SSI_ADDR_GATE_CFG, 16'h0002);
    idle(3);
    ck(gate_open_notice, 1'b0);
    pulse(CYC);
    idle(1);
    ck(auto_running, 1'b1);
    pulse(CST);
    pulse(SOF);
    pulse(COF);
    auto_mode <= 1'b0;
  endtask
  task automatic t_tool();
    wr(SSI_ADDR_CTRL, 16'h0002);
    pulse(REL);
    ck(tool_release_out, 1'b1);
    idle(14);
    pulse(SON);
    ck(spindle_run_out, 1'b0);
    rd(SSI_ADDR_ALARM, 16'h0010);
    wr(SSI_ADDR_ALARM, 16'h007f);
    idle(1);
    ck(alarm_active, 1'b0);
    pulse(CLP);
    ck(tool_release_out, 1'b0);
    idle(14);
    pulse(SON);
    pulse(REL);
    ck(tool_release_out, 1'b0);
    rd(SSI_ADDR_ALARM, 16'h0020);
    pulse(ARS);
    pulse(SOF);
    tool_stall <= 1'b1;
    pulse(REL);
    wait_alarm();
    rd(SSI_ADDR_ALARM, 16'h0008);
    tool_stall <= 1'b0;
    idle(8);
    pulse(ARS);
    tool_stall <= 1'b1;
    pulse(CLP);
    wait_alarm();
    rd(SSI_ADDR_ALARM, 16'h0004);
    tool_stall <= 1'b0;
    pulse(ARS);
  endtask
  task automatic t_key();
    manual_release_key <= 1'b1;
    idle(2);
    ck(tool_release_out, 1'b0);
    rd(SSI_ADDR_ALARM, 16'h0040);
    manual_release_key <= 1'b0;
    pulse(ARS);
    mpg_mode <= 1'b1;
    idle(1);
    manual_release_key <= 1'b1;
    idle(8);
    ck(tool_release_out, 1'b1);
    manual_release_key <= 1'b0;
    idle(2);
    ck(tool_release_out, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_contour();
    t_gate();
    t_tool();
    t_key();
    stop_test();
  end
endmodule // ssi_interlock_tb

/* File: bench/ssi_partner.sv */
// Behavioural model of the spindle drive and the tool clamp switches.
module ssi_partner #(
  parameter int LAT = 3
) (
  // Clock
  input  wire logic clk,
  // Stall controls from the bench
  input  wire logic mode_stall,
  input  wire logic tool_stall,
  // From the interlock
  input  wire logic spindle_mode_switch_out,
  input  wire logic tool_release_out,
  // To the interlock
  output logic      spindle_mode_feedback,
  output logic      release_in_position,
  output logic      clamp_in_position
);
  timeunit 1ns;
  timeprecision 1ns;
  int   mode_cnt = 0;
  int   tool_cnt = 0;
  logic mode_q   = 1'b0;
  logic rel_q    = 1'b0;
  // drive confirms the mode after a delay
  always @(posedge clk) begin
    mode_cnt <= (mode_q == spindle_mode_switch_out || mode_stall) ? 0 : mode_cnt + 1;
    if (mode_cnt == LAT)
      mode_q <= spindle_mode_switch_out;
  end
  always @(posedge clk) begin
    tool_cnt <= (rel_q == tool_release_out || tool_stall) ? 0 : tool_cnt + 1;
    if (tool_cnt == LAT)
      rel_q <= tool_release_out;
  end
  assign spindle_mode_feedback = mode_q;
  // While the tool travels, neither switch is made.
  assign release_in_position = rel_q && tool_release_out;
  assign clamp_in_position   = !rel_q && !tool_release_out;
endmodule // ssi_partner

/* File: src/ssi_interlock.sv */
// Spindle safety interlock: contour axis switch, safety gate and tool clamp.
// Operation
// - Contour-to-position command sets the spindle mode switch output when enabled.
// - Contour-to-speed command clears the spindle mode switch output when enabled.
// - Either contour switch command cancels spindle rotation.
// - Missing mode feedback before contour delay expires after a contour-to-position command raises an alarm.
// - Gate enable bit turns the whole gate function on or off.
// - Polarity bit chooses whether closed gate reads high or low.
// - Open gate with function enabled shows a gate-not-closed notice.
// - Cycle start with gate open is refused and raises an alarm.
// - Gate opening while running halts execution at once.
// - Keep bit decides whether spindle and coolant shut off on gate open.
// - Restart after reclose resumes; spindle and coolant return on.
// - Missing clamp-in-position within clamp delay raises an alarm.
// - Missing release-in-position within clamp delay raises an alarm.
// - Spindle start refused with alarm while tool is released.
// - Tool release or clamp refused with alarm while spindle rotates.
// - Manual release key works only in handwheel mode, else alarm.
// - Held key keeps tool released; letting go clamps it.
// - Release command drives actuator to release, clamp command to clamp.
// - Tool clamp function works only when its enable bit is set.
//
// The address map and the plain strobed port were chosen for this implementation.
module ssi_interlock
  import ssi_pkg::*;
#(
  parameter int TICK_CYCLES = SSI_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [15:0]      reg_rdata,
  // Commands and modes
  input  wire logic        contour_to_position_cmd,
  input  wire logic        contour_to_speed_cmd,
  input  wire logic        tool_release_cmd,
  input  wire logic        tool_clamp_cmd,
  input  wire logic        spindle_start_req,
  input  wire logic        spindle_stop_req,
  input  wire logic        coolant_on_req,
  input  wire logic        coolant_off_req,
  input  wire logic        cycle_start_req,
  input  wire logic        cycle_stop_req,
  input  wire logic        auto_mode,
  input  wire logic        mpg_mode,
  input  wire logic        alarm_reset,
  // Machine inputs
  input  wire logic        spindle_mode_feedback,
  input  wire logic        gate_feedback_in,
  input  wire logic        manual_release_key,
  input  wire logic        release_in_position,
  input  wire logic        clamp_in_position,
  // Outputs
  output logic             spindle_mode_switch_out,
  output logic             spindle_run_out,
  output logic             coolant_out,
  output logic             tool_release_out,
  output logic             auto_running,
  output logic             gate_open_notice,
  output logic             alarm_active
);

  // ==========================================================================
  // Registers
  logic [7:0]             safety_gate_config_reg;
  logic [7:0]             ctrl_reg;
  logic [15:0]            contour_switch_delay_reg;
  logic [15:0]            tool_clamp_delay_reg;
  logic [SSI_ALARM_W-1:0] alarm_reg;
  logic [SSI_ALARM_W-1:0] alarm_set;
  logic [15:0]            rdata_next;
  logic [15:0]            tick_cnt_reg;
  logic                   tick;
  logic                   key_prev_reg;
  logic                   was_spindle_reg;
  logic                   was_coolant_reg;
  ssi_tool_state_t        tool_state_reg;
  ssi_tool_state_t        tool_state_next;

  ssi_timer_if cs_tif ();
  ssi_timer_if tool_tif ();

  // ==========================================================================
  // Scan tick divider
  // Delays count slow ticks, so 16-bit counters span seconds.
  assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (reset || tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // Register access
  // Unmapped indices ignore writes and read as zero.
  wire wr_gate  = reg_write && (reg_addr == SSI_ADDR_GATE_CFG);
  wire wr_ctrl  = reg_write && (reg_addr == SSI_ADDR_CTRL);
  wire wr_csd   = reg_write && (reg_addr == SSI_ADDR_CS_DELAY);
  wire wr_tcd   = reg_write && (reg_addr == SSI_ADDR_CLAMP_DLY);
  wire wr_alarm = reg_write && (reg_addr == SSI_ADDR_ALARM);

  wire gate_en    = safety_gate_config_reg[SSI_GATE_EN_BIT];
  wire keep_sc    = safety_gate_config_reg[SSI_GATE_KEEP_BIT];
  wire cs_en      = ctrl_reg[SSI_CTRL_CS_EN];
  wire clamp_en   = ctrl_reg[SSI_CTRL_CLAMP_EN];
  wire gate_closed = gate_feedback_in == safety_gate_config_reg[SSI_GATE_POL_BIT];
  wire gate_open   = gate_en && !gate_closed;

  // Status is a live snapshot; bit 0 is high while the tool is clamped.
  wire [15:0] status_word = {8'h00,
                             spindle_mode_feedback,
                             tool_release_out,
                             gate_open_notice,
                             auto_running,
                             coolant_out,
                             spindle_run_out,
                             spindle_mode_switch_out,
                             tool_state_reg[0]};

  always_comb begin
    case (reg_addr)
      SSI_ADDR_GATE_CFG:  rdata_next = {8'h00, safety_gate_config_reg};
      SSI_ADDR_CTRL:      rdata_next = {8'h00, ctrl_reg};
      SSI_ADDR_CS_DELAY:  rdata_next = contour_switch_delay_reg;
      SSI_ADDR_CLAMP_DLY: rdata_next = tool_clamp_delay_reg;
      SSI_ADDR_STATUS:    rdata_next = status_word;
      SSI_ADDR_ALARM:     rdata_next = {{(16 - SSI_ALARM_W){1'b0}}, alarm_reg};
      default:            rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      safety_gate_config_reg   <= SSI_GATE_CFG_RST;
      ctrl_reg                 <= SSI_CTRL_RST;
      contour_switch_delay_reg <= SSI_CS_DELAY_RST;
      tool_clamp_delay_reg     <= SSI_CLAMP_DLY_RST;
      reg_rdata                <= 16'h0000;
    end else begin
      if (wr_gate) safety_gate_config_reg <= reg_wdata[7:0];
      if (wr_ctrl) ctrl_reg <= reg_wdata[7:0];
      if (wr_csd) contour_switch_delay_reg <= reg_wdata;
      if (wr_tcd) tool_clamp_delay_reg <= reg_wdata;
      // Read data stand for one cycle only, then fall back to zero.
      reg_rdata <= reg_read ? rdata_next : 16'h0000;
    end
  end

  // ==========================================================================
  // Contour axis switching
  wire cs_pos_go   = cs_en && contour_to_position_cmd;
  wire cs_speed_go = cs_en && contour_to_speed_cmd;

  // A repeated position command does not restart the timer.
  // contour timeout
  assign cs_tif.start = cs_pos_go && !spindle_mode_switch_out;
  assign cs_tif.stop  = spindle_mode_feedback || cs_speed_go;
  assign cs_tif.delay = contour_switch_delay_reg;

  ssi_timeout u_cs_timeout (
    .clk   (clk),
    .reset (reset),
    .tick  (tick),
    .tif   (cs_tif)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      spindle_mode_switch_out <= 1'b0;
    end else if (cs_pos_go) begin
      spindle_mode_switch_out <= 1'b1;
    end else if (cs_speed_go) begin
      spindle_mode_switch_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Tool release and clamp
  wire spin          = spindle_run_out;
  // Rotation and wrong-mode alarms lock the tool out until cleared.
  wire tool_active   = clamp_en && !alarm_reg[SSI_AL_TOOL_ROT] && !alarm_reg[SSI_AL_NOT_MPG];
  // The last key level resets low, its idle level, so no false edge follows reset.
  wire key_edge      = manual_release_key != key_prev_reg;
  wire key_ok        = key_edge && mpg_mode;
  wire rel_req       = tool_release_cmd || (key_ok && manual_release_key);
  wire clp_req       = tool_clamp_cmd || (key_ok && !manual_release_key);
  wire tool_refuse   = clamp_en && (tool_release_cmd || tool_clamp_cmd || key_ok) && spin;
  wire do_release    = tool_active && rel_req && !spin;
  wire do_clamp      = tool_active && clp_req && !spin && tool_state_reg != SSI_TOOL_CLAMPED;
  wire tool_released = tool_state_reg != SSI_TOOL_CLAMPED;
  wire tool_go       = do_release || do_clamp;

  // A release may cut a clamp stroke short; a clamp needs an unclamped tool.
  always_comb begin
    tool_state_next = tool_state_reg;
    case (tool_state_reg)
      SSI_TOOL_CLAMPED:   if (do_release) tool_state_next = SSI_TOOL_RELEASING;
      SSI_TOOL_RELEASING: if (do_clamp) tool_state_next = SSI_TOOL_CLAMPING;
      SSI_TOOL_CLAMPING: begin
        if (do_release) begin
          tool_state_next = SSI_TOOL_RELEASING;
        end else if (clamp_in_position) begin
          tool_state_next = SSI_TOOL_CLAMPED;
        end
      end
      default:            tool_state_next = SSI_TOOL_CLAMPED;
    endcase
  end

  // release and clamp timeout
  // A new stroke outranks the end switch of the old one, so its timer always starts.
  assign tool_tif.start = tool_go;
  assign tool_tif.stop  = !clamp_en || (!tool_go &&
                          ((tool_state_reg == SSI_TOOL_RELEASING && release_in_position) ||
                           (tool_state_reg == SSI_TOOL_CLAMPING && clamp_in_position)));
  assign tool_tif.delay = tool_clamp_delay_reg;

  ssi_timeout u_tool_timeout (
    .clk   (clk),
    .reset (reset),
    .tick  (tick),
    .tif   (tool_tif)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      tool_state_reg   <= SSI_TOOL_CLAMPED;
      tool_release_out <= 1'b0;
      key_prev_reg     <= 1'b0;
    end else begin
      key_prev_reg     <= manual_release_key;
      tool_state_reg   <= tool_state_next;
      tool_release_out <= (tool_state_next == SSI_TOOL_RELEASING);
    end
  end

  // ==========================================================================
  // Safety gate, spindle, coolant and automatic running
  // Spindle and coolant are remembered only when the gate shuts them,
  // so a restart brings back what was lost and nothing more.
  // start refused
  wire start_refused = auto_mode && cycle_start_req && (gate_open || alarm_reg[SSI_AL_GATE_START]);
  // The start is held off only while the tool function is enabled.
  // start while released
  wire spin_refused  = spindle_start_req && clamp_en && tool_released;
  wire gate_trip     = gate_open && auto_running;
  wire gate_shut     = gate_trip && !keep_sc;
  wire restart_ok    = auto_mode && cycle_start_req && !start_refused;

  always_ff @(posedge clk) begin
    if (reset) begin
      auto_running     <= 1'b0;
      spindle_run_out  <= 1'b0;
      coolant_out      <= 1'b0;
      gate_open_notice <= 1'b0;
      was_spindle_reg  <= 1'b0;
      was_coolant_reg  <= 1'b0;
    end else begin
      gate_open_notice <= gate_open;
      if (gate_trip || cycle_stop_req || !auto_mode) begin
        auto_running <= 1'b0;
      end else if (restart_ok) begin
        auto_running <= 1'b1;
      end
      if (gate_shut) begin
        was_spindle_reg <= spindle_run_out;
        was_coolant_reg <= coolant_out;
      end
      if (contour_to_position_cmd || contour_to_speed_cmd || gate_shut || spindle_stop_req) begin
        spindle_run_out <= 1'b0;
      end else if (spindle_start_req && !spin_refused) begin
        spindle_run_out <= 1'b1;
      end else if (restart_ok && was_spindle_reg) begin
        spindle_run_out <= 1'b1;
      end
      if (gate_shut || coolant_off_req) begin
        coolant_out <= 1'b0;
      end else if (coolant_on_req || (restart_ok && was_coolant_reg)) begin
        coolant_out <= 1'b1;
      end
      if (restart_ok) begin
        was_spindle_reg <= 1'b0;
        was_coolant_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Alarms
  // Each bit is a one-cycle set request; the latch below holds it.
  always_comb begin
    alarm_set                    = '0;
    alarm_set[SSI_AL_CS_TIMEOUT] = cs_tif.expired;
    alarm_set[SSI_AL_GATE_START] = start_refused && gate_open;
    alarm_set[SSI_AL_CLAMP_TO]   = tool_tif.expired && tool_state_reg == SSI_TOOL_CLAMPING;
    alarm_set[SSI_AL_RELEASE_TO] = tool_tif.expired && tool_state_reg == SSI_TOOL_RELEASING;
    alarm_set[SSI_AL_START_REL]  = spin_refused;
    alarm_set[SSI_AL_TOOL_ROT]   = tool_refuse;
    alarm_set[SSI_AL_NOT_MPG]    = clamp_en && key_edge && !mpg_mode;
  end

  // The operator key clears every alarm, a register write the bits set in it.
  wire [SSI_ALARM_W-1:0] alarm_clr  = alarm_reset ? {SSI_ALARM_W{1'b1}} :
                                      (wr_alarm ? reg_wdata[SSI_ALARM_W-1:0] :
                                       {SSI_ALARM_W{1'b0}});
  // A new event wins over a clear in the same cycle.
  wire [SSI_ALARM_W-1:0] alarm_next = alarm_set | (alarm_reg & ~alarm_clr);

  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_reg    <= '0;
      alarm_active <= 1'b0;
    end else begin
      alarm_reg    <= alarm_next;
      alarm_active <= |alarm_next;
    end
  end

endmodule // ssi_interlock

/* File: src/ssi_pkg.sv */
// Package of constants, register map and state types for the spindle safety interlock.
package ssi_pkg;

  // ==========================================================================
  // Register map
  localparam logic [3:0] SSI_ADDR_GATE_CFG   = 4'h0;
  localparam logic [3:0] SSI_ADDR_CTRL       = 4'h1;
  localparam logic [3:0] SSI_ADDR_CS_DELAY   = 4'h2;
  localparam logic [3:0] SSI_ADDR_CLAMP_DLY  = 4'h3;
  localparam logic [3:0] SSI_ADDR_STATUS     = 4'h4;
  localparam logic [3:0] SSI_ADDR_ALARM      = 4'h5;

  // ==========================================================================
  // Field positions
  localparam int SSI_GATE_EN_BIT    = 0;
  localparam int SSI_GATE_POL_BIT   = 1;
  localparam int SSI_GATE_KEEP_BIT  = 2;
  localparam int SSI_CTRL_CS_EN     = 0;
  localparam int SSI_CTRL_CLAMP_EN  = 1;

  // Alarm bit positions.
  localparam int SSI_AL_CS_TIMEOUT  = 0;
  localparam int SSI_AL_GATE_START  = 1;
  localparam int SSI_AL_CLAMP_TO    = 2;
  localparam int SSI_AL_RELEASE_TO  = 3;
  localparam int SSI_AL_START_REL   = 4;
  localparam int SSI_AL_TOOL_ROT    = 5;
  localparam int SSI_AL_NOT_MPG     = 6;
  localparam int SSI_ALARM_W        = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  SSI_GATE_CFG_RST  = 8'h00;
  localparam logic [7:0]  SSI_CTRL_RST      = 8'h00;
  localparam logic [15:0] SSI_CS_DELAY_RST  = 16'h03e8;
  localparam logic [15:0] SSI_CLAMP_DLY_RST = 16'h03e8;

  // Scan tick: delays count in milliseconds of a 20 MHz clock.
  localparam int SSI_CLK_HZ       = 20000000;
  localparam int SSI_TICK_US      = 1000;
  localparam int SSI_TICK_CYCLES  = SSI_CLK_HZ / 1000000 * SSI_TICK_US;

  typedef enum logic [2:0] {
    SSI_TOOL_CLAMPED   = 3'b001,
    SSI_TOOL_RELEASING = 3'b010,
    SSI_TOOL_CLAMPING  = 3'b100
  } ssi_tool_state_t;

endpackage

/* File: src/ssi_timeout.sv */
// Loadable down counter that flags a timeout in scan ticks.
module ssi_timeout (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   tick,
  // Control
  ssi_timer_if.timer  tif
);

  logic [15:0] count_reg;
  logic        run_reg;
  logic        exp_reg;

  assign tif.expired = exp_reg;
  assign tif.running = run_reg;

  always_ff @(posedge clk) begin
    if (reset || tif.stop) begin
      count_reg <= 16'h0000;
      run_reg   <= 1'b0;
      exp_reg   <= 1'b0;
    end else if (tif.start) begin
      count_reg <= tif.delay;
      run_reg   <= 1'b1;
      exp_reg   <= 1'b0;
    end else if (run_reg && tick) begin
      if (count_reg == 16'h0000) begin
        run_reg <= 1'b0;
        exp_reg <= 1'b1;
      end else begin
        count_reg <= count_reg - 16'h0001;
      end
    end else begin
      exp_reg <= 1'b0;
    end
  end

endmodule // ssi_timeout

/* File: src/ssi_timer_if.sv */
// Interface joining the interlock to one timeout counter.
interface ssi_timer_if;
  logic        start;
  logic        stop;
  logic [15:0] delay;
  logic        expired;
  logic        running;
  modport ctrl (output start, output stop, output delay, input expired, input running);
  modport timer (input start, input stop, input delay, output expired, output running);
endinterface
